// ### core/bdsc_pkg.sv
// Constants shared by the boost, dither and sync configuration bank
package bdsc_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [9:0] BDSC_IDX_CFG = 10'h0a5;
  localparam logic [9:0] BDSC_IDX_LOCK_HI = 10'h0a6;
  localparam logic [9:0] BDSC_IDX_CTRL = 10'h0b0;
  localparam logic [9:0] BDSC_IDX_STATUS = 10'h0b1;
  localparam int BDSC_ADDR_W = 12;
  // Field positions in the configuration register
  localparam int BDSC_SYNC_EN_BIT = 7;
  localparam int BDSC_DITHER_MSB = 6;
  localparam int BDSC_DITHER_LSB = 5;
  localparam int BDSC_BOOST_MSB = 4;
  localparam int BDSC_BOOST_LSB = 0;
  // Field positions in the neighbouring register and own control register
  localparam int BDSC_LOCK_LO_MSB = 7;
  localparam int BDSC_LOCK_LO_LSB = 3;
  localparam int BDSC_ADAPT_BIT = 0;
  localparam int BDSC_LOCK_W = 13;
  // Reset values
  localparam logic [7:0] BDSC_CFG_RST = 8'h00;
  localparam logic [7:0] BDSC_LOCK_HI_RST = 8'h00;
  localparam logic [7:0] BDSC_CTRL_RST = 8'h00;
  // Boost voltage mapping in volts
  localparam logic [5:0] BDSC_BOOST_BASE_V = 6'h0a;
  localparam logic [5:0] BDSC_BOOST_MAX_V = 6'h28;
  localparam logic [4:0] BDSC_BOOST_SAT_CODE = 5'h1e;
  // Synthesiser divide factors per resolution setting
  localparam logic [7:0] BDSC_FACTOR_0 = 8'h1a;
  localparam logic [7:0] BDSC_FACTOR_1 = 8'h32;
  localparam logic [7:0] BDSC_FACTOR_2 = 8'h62;
  localparam logic [7:0] BDSC_FACTOR_3 = 8'hc4;
endpackage : bdsc_pkg

// ### core/bdsc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
module bdsc_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level_q,
  output logic rise_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Level moves only once the last two stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      rise_q <= (s2_q == s3_q) && s3_q && !level_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end
endmodule : bdsc_pin_sync

// ### core/bdsc_config.sv
// Boost, dither and frame sync configuration bank with APB access
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
module bdsc_config
  import bdsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [BDSC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vsync_pin,
  input wire logic [7:0] neighbour_cfg,
  input wire logic [1:0] pwm_resolution,
  output logic sync_enable_q,
  output logic sync_pulse_q,
  output logic [BDSC_LOCK_W-1:0] lock_count_q,
  output logic [1:0] synth_freq_sel_q,
  output logic [7:0] lock_factor_q,
  output logic [1:0] dither_bits_q,
  output logic [5:0] boost_volts_q,
  output logic boost_load_q,
  output logic boost_fixed_q
);
  logic [7:0] cfg_q;
  logic [7:0] lock_hi_q;
  logic [7:0] ctrl_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic vs_level;
  logic vs_rise;
  logic [9:0] idx;
  logic aligned;
  logic setup;
  logic wr_cfg;
  logic wr_ctrl;
  logic [4:0] code;
  logic adapt;

  assign idx = paddr[BDSC_ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup = psel && !penable;
  assign wr_cfg = psel && penable && pready_q && pwrite && aligned && (idx == BDSC_IDX_CFG);
  assign wr_ctrl = psel && penable && pready_q && pwrite && aligned && (idx == BDSC_IDX_CTRL);
  assign code = cfg_q[BDSC_BOOST_MSB:BDSC_BOOST_LSB];
  assign adapt = ctrl_q[BDSC_ADAPT_BIT];
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  bdsc_pin_sync u_vsync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(vsync_pin),
    .level_q(vs_level),
    .rise_q(vs_rise)
  );

  // Answer is prepared in the setup cycle and ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= 1'b0;
        prdata_q <= 32'h0000_0000;
        if (!aligned) begin
          pslverr_q <= 1'b1;
        end else if (idx == BDSC_IDX_CFG) begin
          prdata_q <= {24'h000000, cfg_q};
        end else if (idx == BDSC_IDX_LOCK_HI) begin
          prdata_q <= {24'h000000, lock_hi_q};
        end else if (idx == BDSC_IDX_CTRL) begin
          prdata_q <= {24'h000000, ctrl_q};
        end else if (idx == BDSC_IDX_STATUS) begin
          prdata_q <= {30'h00000000, cfg_q[BDSC_SYNC_EN_BIT], vs_level};
        end else begin
          pslverr_q <= 1'b1;
        end
      end
    end
  end

  // Register writes at the completing access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= BDSC_CFG_RST;
      lock_hi_q <= BDSC_LOCK_HI_RST;
      ctrl_q <= BDSC_CTRL_RST;
    end else if (psel && penable && pready_q && pwrite && aligned) begin
      if (idx == BDSC_IDX_CFG) begin
        cfg_q <= pwdata[7:0];
      end else if (idx == BDSC_IDX_LOCK_HI) begin
        lock_hi_q <= pwdata[7:0];
      end else if (idx == BDSC_IDX_CTRL) begin
        ctrl_q <= {7'h00, pwdata[BDSC_ADAPT_BIT]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_enable_q <= 1'b0;
      sync_pulse_q <= 1'b0;
    end else begin
      sync_enable_q <= cfg_q[BDSC_SYNC_EN_BIT];
      sync_pulse_q <= cfg_q[BDSC_SYNC_EN_BIT] && vs_rise;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dither_bits_q <= 2'b00;
    end else begin
      dither_bits_q <= cfg_q[BDSC_DITHER_MSB:BDSC_DITHER_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_volts_q <= BDSC_BOOST_BASE_V;
    end else if (code >= BDSC_BOOST_SAT_CODE) begin
      boost_volts_q <= BDSC_BOOST_MAX_V;
    end else begin
      boost_volts_q <= BDSC_BOOST_BASE_V + {1'b0, code};
    end
  end

  // regulator start load or fixed voltage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_load_q <= 1'b0;
      boost_fixed_q <= 1'b1;
    end else begin
      boost_fixed_q <= !adapt;
      boost_load_q <= (adapt && wr_cfg) || (wr_ctrl && !adapt && pwdata[BDSC_ADAPT_BIT]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_count_q <= 13'h0000;
    end else if (cfg_q[BDSC_SYNC_EN_BIT]) begin
      lock_count_q <= {lock_hi_q, neighbour_cfg[BDSC_LOCK_LO_MSB:BDSC_LOCK_LO_LSB]};
    end else begin
      lock_count_q <= 13'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      synth_freq_sel_q <= 2'b00;
      lock_factor_q <= BDSC_FACTOR_0;
    end else begin
      synth_freq_sel_q <= pwm_resolution;
      case (pwm_resolution)
        2'b00: lock_factor_q <= BDSC_FACTOR_0;
        2'b01: lock_factor_q <= BDSC_FACTOR_1;
        2'b10: lock_factor_q <= BDSC_FACTOR_2;
        default: lock_factor_q <= BDSC_FACTOR_3;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_cfg_write;
    wr_cfg ##1 adapt;
  endsequence

  AST_SYNC_GATED: assert property (sync_pulse_q |-> $past(cfg_q[BDSC_SYNC_EN_BIT]))
    else $error("sync pulse passed while sync disabled");
  AST_DITHER: assert property (##1 dither_bits_q == $past(cfg_q[BDSC_DITHER_MSB:BDSC_DITHER_LSB]))
    else $error("dither depth does not follow field");
  AST_BOOST_LIN: assert property (code < BDSC_BOOST_SAT_CODE |=> boost_volts_q == 6'h0a + {1'b0, $past(code)})
    else $error("boost voltage not linear in code");
  AST_BOOST_TOP: assert property (code == 5'h1f || code == 5'h1e |=> boost_volts_q == 6'h28)
    else $error("top boost codes not 40V");
  AST_ADAPT_LOAD: assert property (s_cfg_write |-> boost_load_q)
    else $error("adaptive start value not loaded");
  AST_FIXED: assert property (!adapt && !wr_ctrl |=> boost_fixed_q && !boost_load_q)
    else $error("boost not fixed with adaptive off");
  AST_LOCK_HI: assert property (cfg_q[7] |=> lock_count_q[12:5] == $past(lock_hi_q))
    else $error("lock count upper byte wrong");
  AST_LOCK_OFF: assert property (!cfg_q[7] |=> lock_count_q == 13'h0000)
    else $error("lock count active while sync disabled");
  AST_LOCK_LO: assert property (cfg_q[7] |=> lock_count_q[4:0] == $past(neighbour_cfg[7:3]))
    else $error("lock count lower bits wrong");
  AST_FACTOR: assert property (pwm_resolution == 2'b11 |=> lock_factor_q == 8'hc4 && synth_freq_sel_q == 2'b11)
    else $error("divide factor wrong for top resolution");
endmodule : bdsc_config

// ### sim/bdsc_apb_host.sv
// APB host model that programs the configuration bank
`timescale 1ns/10ps
module bdsc_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Call right after a rising edge; the answer is taken at the rising edge where pready is high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : bdsc_apb_host

// ### sim/boost_dither_sync_config_tb.sv
// Self-checking bench for the configuration bank
`timescale 1ns/10ps
module boost_dither_sync_config_tb;
  import bdsc_pkg::*;
  localparam logic [11:0] a_cfg = {BDSC_IDX_CFG, 2'b00};
  localparam logic [11:0] a_lock = {BDSC_IDX_LOCK_HI, 2'b00};
  localparam logic [11:0] a_ctrl = {BDSC_IDX_CTRL, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, vsync_pin = 1'b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] neighbour_cfg = 8'h28, lock_factor_q;
  logic [1:0] pwm_resolution = 2'h0, synth_freq_sel_q, dither_bits_q;
  logic sync_enable_q, sync_pulse_q, boost_load_q, boost_fixed_q;
  logic [12:0] lock_count_q;
  logic [5:0] boost_volts_q;
  int miscompares = 0, checks_done = 0, pulses = 0, loads = 0;
  bdsc_config i_bdsc_config (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vsync_pin(vsync_pin),
    .neighbour_cfg(neighbour_cfg), .pwm_resolution(pwm_resolution), .sync_enable_q(sync_enable_q),
    .sync_pulse_q(sync_pulse_q), .lock_count_q(lock_count_q), .synth_freq_sel_q(synth_freq_sel_q),
    .lock_factor_q(lock_factor_q), .dither_bits_q(dither_bits_q), .boost_volts_q(boost_volts_q),
    .boost_load_q(boost_load_q), .boost_fixed_q(boost_fixed_q));
  bdsc_apb_host i_bdsc_apb_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    pulses += (sync_pulse_q === 1'b1);
    loads += (boost_load_q === 1'b1);
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic rw(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    i_bdsc_apb_host.xfer(w, a, {24'h0, d}, r, e);
    if (!w) chk(r, x, "read data");
    chk({31'h0, e}, {31'h0, xe}, "error response");
    repeat (3) @(posedge pclk);
  endtask : rw
  task automatic t_boost_dither;
    for (int c = 0; c < 32; c++) begin
      rw(1'b1, a_cfg, {1'b0, c[1:0], c[4:0]}, 32'h0, 1'b0);
      chk({26'h0, boost_volts_q}, (c >= 30) ? 32'h28 : 32'h0a + c, "boost volts");
      chk({30'h0, dither_bits_q}, {30'h0, c[1:0]}, "dither bits");
    end
    rw(1'b0, a_cfg, 8'h00, 32'h7f, 1'b0);
  endtask : t_boost_dither
  task automatic t_lock_sync(input logic en, input logic [12:0] xl, input int xp);
    rw(1'b1, a_cfg, {en, 7'h00}, 32'h0, 1'b0);
    pulses = 0;
    vsync_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    vsync_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    chk(pulses, xp, "sync pulses");
    chk({31'h0, sync_enable_q}, {31'h0, en}, "sync enable");
    chk({19'h0, lock_count_q}, {19'h0, xl}, "lock count");
  endtask : t_lock_sync
  task automatic t_adaptive(input logic ad, input int xl);
    loads = 0;
    rw(1'b1, a_ctrl, {7'h00, ad}, 32'h0, 1'b0);
    chk(loads, {31'h0, ad}, "load on adaptive enable");
    rw(1'b0, a_ctrl, 8'h00, {31'h0, ad}, 1'b0);
    loads = 0;
    rw(1'b1, a_cfg, 8'h05, 32'h0, 1'b0);
    chk(loads, xl, "start voltage loads");
    chk({31'h0, boost_fixed_q}, {31'h0, !ad}, "fixed boost");
  endtask : t_adaptive
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({26'h0, boost_volts_q}, 32'h0a, "boost after reset");
    rw(1'b0, a_lock, 8'h00, 32'h0, 1'b0);
    t_boost_dither();
    rw(1'b1, a_lock, 8'h64, 32'h0, 1'b0);
    rw(1'b0, a_lock, 8'h00, 32'h64, 1'b0);
    t_lock_sync(1'b0, 13'h0000, 0);
    t_lock_sync(1'b1, 13'h0c85, 1);
    rw(1'b0, {BDSC_IDX_STATUS, 2'b00}, 8'h00, 32'h2, 1'b0);
    // Resolution picks rate and factor
    for (int s = 0; s < 4; s++) begin
      pwm_resolution <= s[1:0];
      repeat (3) @(posedge pclk);
      chk({30'h0, synth_freq_sel_q}, s, "synth rate");
      chk({24'h0, lock_factor_q}, (s == 0) ? 32'h1a : (s == 1) ? 32'h32 : (s == 2) ? 32'h62 : 32'hc4, "factor");
    end
    t_adaptive(1'b1, 1);
    t_adaptive(1'b0, 0);
    rw(1'b0, 12'h300, 8'h00, 32'h0, 1'b1);
    rw(1'b1, 12'h295, 8'hff, 32'h0, 1'b1);
    rw(1'b0, a_cfg, 8'h00, 32'h05, 1'b0);
    wrap_up();
  end
endmodule : boost_dither_sync_config_tb
